/* sfrs_pkg.sv */
// Constants and types for the packet serial channel receive status block
package sfrs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CHAN_MODE = 8'h84;
    localparam logic [7:0] IDX_PWR_CTRL  = 8'h87;
    localparam logic [7:0] IDX_BACKOFF_RANDOM_SOURCE      = 8'he4;
    localparam logic [7:0] IDX_RECEIVE_STATUS     = 8'he8;
    localparam logic [7:0] IDX_RECEIVE_FIFO_PORT     = 8'hf4;
    localparam logic [7:0] IDX_SLOT      = 8'hf5;
    // channel_mode_config fields
    localparam int MD_PROTO = 0;
    localparam int MD_CRC32 = 3;
    // power_and_channel_control fields
    localparam int PC_FLAG_IDLE = 2;
    localparam int PC_EXT_RXCLK = 3;
    localparam int PC_AUX_RX    = 4;
    // receive_status fields
    localparam int ST_HWACK = 0;
    localparam int ST_REN   = 1;
    localparam int ST_NE    = 2;
    localparam int ST_DONE  = 3;
    localparam int ST_CRC_ERROR  = 4;
    localparam int ST_AE    = 5;
    localparam int ST_ABT   = 6;
    localparam int ST_OVR   = 7;
    // station_slot_config fields
    localparam int SL_JAM = 7;
    localparam int SL_DET = 6;
    // Reset values
    localparam logic [7:0] REG_RST   = 8'h00;
    localparam logic [7:0] BACKOFF_RANDOM_SOURCE_SEED = 8'hff;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    // CRC polynomials and good-frame residues
    localparam logic [31:0] CRC16_POLY = 32'h00001021;
    localparam logic [31:0] CRC32_POLY = 32'h04c11db7;
    localparam logic [15:0] CRC16_RES  = 16'h1d0f;
    localparam logic [31:0] CRC32_RES  = 32'hc704dd7b;
    localparam logic [5:0]  JAM16_BITS = 6'h10;
    localparam logic [5:0]  JAM32_BITS = 6'h20;
    // Line codes and counts
    localparam logic [7:0] IDLE_FLAG  = 8'h7e;
    localparam logic [1:0] FIFO_DEPTH = 2'h3;
    localparam logic [2:0] ONES_FLAG  = 3'h6;
    localparam logic [2:0] ONES_STUFF = 3'h5;
    localparam logic [2:0] ONES_MAX   = 3'h7;
    localparam logic [2:0] IDLE_HALF  = 3'h4;
    // Timing: internal sample and transmit bit periods
    localparam int CLK_NS  = 20;
    localparam int TICK_NS = 160;
    localparam int TICK_CYC_I = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] TICK_CYC = TICK_CYC_I[7:0];
    typedef enum logic {FR_HUNT, FR_DATA} sfrs_frame_e;
endpackage

/* sfrs_top.sv */
// Receive status, receive FIFO, backoff and line driver of the channel
`timescale 1ns/1ps
module sfrs_top
    import sfrs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_data_pin,
    input  wire logic        rx_clk_pin,
    input  wire logic        tx_busy,
    input  wire logic        tx_bit,
    output logic             tx_line,
    output logic             collision,
    output logic      [5:0]  backoff_slot,
    output logic             backoff_join,
    output logic             hw_ack_en
);
    // Byte-wise CRC, used only by the receive check
    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0]  d,
                                             input logic        w32);
        logic [31:0] r;
        logic        fb;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            fb = (w32 ? r[31] : r[15]) ^ d[i];
            r = {r[30:0], 1'b0};
            if (fb)
                r = r ^ (w32 ? CRC32_POLY : CRC16_POLY);
        end
        if (!w32)
            r[31:16] = 16'h0000;
        return r;
    endfunction

    // FIFO pointer step with wrap at three entries
    function automatic logic [1:0] ptr_next(input logic [1:0] p);
        return (p == FIFO_DEPTH - 2'h1) ? 2'h0 : p + 2'h1;
    endfunction

    logic [7:0]  mode_q, pctl_q, slot_q, backoff_random_source_q;
    logic        hwack_q, ren_q, done_q, crc_error_q, ae_q, abt_q, ovr_q;
    logic        rxd_s1, rxd_s2, rxc_s1, rxc_s2, rxc_s3;
    logic [7:0]  rx_div_q, tx_div_q;
    logic        lvl_q, half_q, phase_q, prev_q;
    logic [2:0]  ones_q, idle_q;
    sfrs_frame_e frm_q;
    logic [7:0]  sh_q;
    logic [2:0]  bcnt_q;
    logic        any_q;
    logic [31:0] crc_q;
    logic [7:0]  mem [0:2];
    logic [1:0]  wp_q, rp_q, cnt_q;
    logic [5:0]  jam_q;
    logic [31:0] jsh_q;
    logic [7:0]  flag_q;
    logic        sdlc, crc32, acc, wr, rd_hit;
    logic        rx_tick, tx_tick, bit_v, bit_d, coll_ev, eof_ev;
    logic        flag_ev, stuff_ev, abt_line, bof_ev, shift_ev, byte_ev;
    logic        pop, push, ovr_ev, end_ev, abt_ev, aligned, crc_ok;
    logic        fin_done, fin_crc_error, fin_ae, keep, rx_stop, ren_set;
    logic [7:0]  rd_val, new_byte;

    assign sdlc  = mode_q[MD_PROTO];
    assign crc32 = mode_q[MD_CRC32];

    // APB completion edge and register decode
    assign acc    = psel & penable & pready;
    assign wr     = acc & pwrite;
    assign rd_hit = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
    assign ren_set = wr & rd_hit & (paddr[9:2] == IDX_RECEIVE_STATUS) & pwdata[ST_REN];

    // Read mux; unmapped addresses read zero with an error
    always_comb
    begin
        rd_val = 8'h00;
        case (paddr[9:2])
            IDX_CHAN_MODE: rd_val = mode_q;
            IDX_PWR_CTRL:  rd_val = pctl_q;
            IDX_BACKOFF_RANDOM_SOURCE:      rd_val = backoff_random_source_q;
            IDX_RECEIVE_STATUS:     rd_val = {ovr_q, abt_q, ae_q, crc_error_q, done_q,
                                     cnt_q != 2'h0, ren_q, hwack_q};
            IDX_RECEIVE_FIFO_PORT:     rd_val = (cnt_q != 2'h0) ? mem[rp_q] : 8'h00;
            IDX_SLOT:      rd_val = slot_q;
            default:       rd_val = 8'h00;
        endcase
    end

    // One wait state on every access, then data and error together
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            prdata  <= {24'h000000, rd_hit ? rd_val : 8'h00};
            pslverr <= psel & penable & ~pready & ~(rd_hit &
                       (paddr[9:2] == IDX_CHAN_MODE ||
                        paddr[9:2] == IDX_PWR_CTRL ||
                        paddr[9:2] == IDX_BACKOFF_RANDOM_SOURCE ||
                        paddr[9:2] == IDX_RECEIVE_STATUS ||
                        paddr[9:2] == IDX_RECEIVE_FIFO_PORT ||
                        paddr[9:2] == IDX_SLOT));
        end
    end

    // Software configuration registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mode_q  <= REG_RST;
            pctl_q  <= REG_RST;
            slot_q  <= REG_RST;
            hwack_q <= 1'b0;
        end
        else if (wr & rd_hit)
        begin
            if (paddr[9:2] == IDX_CHAN_MODE)
                mode_q <= pwdata[7:0];
            if (paddr[9:2] == IDX_PWR_CTRL)
                pctl_q <= pwdata[7:0];
            if (paddr[9:2] == IDX_SLOT)
                slot_q <= pwdata[7:0];
            if (paddr[9:2] == IDX_RECEIVE_STATUS)
                hwack_q <= pwdata[ST_HWACK];
        end
    end

    // Free-running LFSR; read at any time for random backoff
    always_ff @(posedge mclk)
    begin
        if (rst)
            backoff_random_source_q <= BACKOFF_RANDOM_SOURCE_SEED;
        else
            backoff_random_source_q <= {backoff_random_source_q[6:0],
                       backoff_random_source_q[7] ^ backoff_random_source_q[5] ^ backoff_random_source_q[4] ^ backoff_random_source_q[3]};
    end

    // Pin synchronisers; only stage two and three are read
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            {rxd_s2, rxd_s1} <= 2'b11;
            {rxc_s3, rxc_s2, rxc_s1} <= 3'b000;
        end
        else
        begin
            {rxd_s2, rxd_s1} <= {rxd_s1, rx_data_pin};
            {rxc_s3, rxc_s2, rxc_s1} <= {rxc_s2, rxc_s1, rx_clk_pin};
        end
    end

    // Internal sample and bit dividers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rx_div_q <= 8'h00;
            tx_div_q <= 8'h00;
        end
        else
        begin
            rx_div_q <= (rx_div_q == TICK_CYC - 8'h01) ? 8'h00 : rx_div_q + 8'h01;
            tx_div_q <= (tx_div_q == TICK_CYC - 8'h01) ? 8'h00 : tx_div_q + 8'h01;
        end
    end
    // Receiver alone may follow the external clock edge
    assign rx_tick = pctl_q[PC_EXT_RXCLK] ? (rxc_s2 & ~rxc_s3)
                                          : (rx_div_q == TICK_CYC - 8'h01);
    assign tx_tick = (tx_div_q == TICK_CYC - 8'h01);

    // Line decode: NRZI bits or Manchester half-bit pairs
    always_comb
    begin
        bit_v   = 1'b0;
        bit_d   = 1'b0;
        coll_ev = 1'b0;
        eof_ev  = 1'b0;
        if (rx_tick)
        begin
            if (sdlc)
            begin
                bit_v = 1'b1;
                bit_d = (rxd_s2 == lvl_q);
            end
            else if (phase_q)
            begin
                bit_v = (half_q != rxd_s2);
                bit_d = rxd_s2;
                // Low-low pair is a violation: seen regardless of enable
                coll_ev = ~half_q & ~rxd_s2;
            end
            eof_ev = ~sdlc & rxd_s2 & (idle_q == IDLE_HALF - 3'h1);
        end
    end

    // Decoder state: level, phase, ones run, idle run
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            lvl_q   <= 1'b1;
            half_q  <= 1'b1;
            phase_q <= 1'b0;
            prev_q  <= 1'b0;
            ones_q  <= 3'h0;
            idle_q  <= 3'h0;
        end
        else
        begin
            if (rx_tick)
            begin
                lvl_q  <= rxd_s2;
                half_q <= rxd_s2;
                // Hunting with no mid-bit change means phase is wrong
                phase_q <= ~phase_q | (frm_q == FR_HUNT & phase_q &
                                       half_q == rxd_s2);
                idle_q <= (rxd_s2 & idle_q != IDLE_HALF) ? idle_q + 3'h1
                        : (rxd_s2 ? idle_q : 3'h0);
            end
            if (bit_v)
            begin
                prev_q <= bit_d;
                ones_q <= ~bit_d ? 3'h0
                        : (ones_q == ONES_MAX ? ONES_MAX : ones_q + 3'h1);
            end
        end
    end

    // Frame events
    assign flag_ev  = sdlc & bit_v & ~bit_d & (ones_q == ONES_FLAG);
    assign stuff_ev = sdlc & bit_v & ~bit_d & (ones_q == ONES_STUFF);
    assign abt_line = sdlc & bit_v & bit_d & (ones_q == ONES_FLAG);
    assign bof_ev   = ~sdlc & bit_v & bit_d & prev_q;
    assign shift_ev = (frm_q == FR_DATA) & bit_v & ~stuff_ev & ~flag_ev;
    assign byte_ev  = shift_ev & (bcnt_q == 3'h7);
    assign new_byte = {bit_d, sh_q[7:1]};
    assign pop  = acc & ~pwrite & rd_hit & (paddr[9:2] == IDX_RECEIVE_FIFO_PORT)
                & (cnt_q != 2'h0);
    assign push   = byte_ev & ((cnt_q != FIFO_DEPTH) | pop);
    assign ovr_ev = byte_ev & (cnt_q == FIFO_DEPTH) & ~pop;
    assign end_ev = (frm_q == FR_DATA) & any_q & (sdlc ? flag_ev : eof_ev);
    assign abt_ev = (frm_q == FR_DATA) & any_q & (sdlc ? abt_line : coll_ev);
    // Flag leaves seven of its bits in the shifter when byte-aligned
    assign aligned = sdlc ? (bcnt_q == 3'h7) : (bcnt_q == 3'h0);
    assign crc_ok  = crc32 ? (crc_q == CRC32_RES)
                           : (crc_q[15:0] == CRC16_RES);
    // Good CRC in CSMA/CD forgives dribble bits
    assign fin_ae   = end_ev & ~aligned & (sdlc | ~crc_ok);
    assign fin_crc_error = end_ev & ~crc_ok & (aligned | sdlc);
    assign fin_done = end_ev & crc_ok & (aligned | ~sdlc) & ~ovr_q;
    assign keep = sdlc & pctl_q[PC_AUX_RX] & fin_done;
    assign rx_stop = (end_ev & ~keep) | abt_ev | ovr_ev;

    // Frame assembly; bytes enter the CRC as they complete
    always_ff @(posedge mclk)
    begin
        if (rst | ren_set)
        begin
            frm_q  <= FR_HUNT;
            sh_q   <= 8'h00;
            bcnt_q <= 3'h0;
            any_q  <= 1'b0;
            crc_q  <= CRC_INIT;
        end
        else
        begin
            case (frm_q)
                FR_HUNT:
                begin
                    if (ren_q & (sdlc ? flag_ev : bof_ev))
                    begin
                        frm_q  <= FR_DATA;
                        bcnt_q <= 3'h0;
                        any_q  <= 1'b0;
                        crc_q  <= CRC_INIT;
                    end
                end
                FR_DATA:
                begin
                    if (~ren_q | abt_ev | ovr_ev | abt_line)
                        frm_q <= FR_HUNT;
                    else if (flag_ev)
                    begin
                        // Closing flag may open the next frame
                        bcnt_q <= 3'h0;
                        any_q  <= 1'b0;
                        crc_q  <= CRC_INIT;
                        if (end_ev & ~keep)
                            frm_q <= FR_HUNT;
                    end
                    else if (eof_ev)
                        frm_q <= FR_HUNT;
                    else if (shift_ev)
                    begin
                        sh_q   <= new_byte;
                        bcnt_q <= bcnt_q + 3'h1;
                        if (byte_ev)
                        begin
                            any_q <= 1'b1;
                            crc_q <= crc_byte(crc_q, new_byte, crc32);
                        end
                    end
                end
                default: frm_q <= FR_HUNT;
            endcase
        end
    end

    // Receive FIFO; enable set flushes it
    always_ff @(posedge mclk)
    begin
        if (rst | ren_set)
        begin
            wp_q  <= 2'h0;
            rp_q  <= 2'h0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
                wp_q <= ptr_next(wp_q);
            if (pop)
                rp_q <= ptr_next(rp_q);
            // Count settles the edge after a read
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wp_q] <= new_byte;
    end

    // Receive status flags; hardware set wins over any clear
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ren_q  <= 1'b0;
            done_q <= 1'b0;
            crc_error_q <= 1'b0;
            ae_q   <= 1'b0;
            abt_q  <= 1'b0;
            ovr_q  <= 1'b0;
        end
        else
        begin
            if (ren_set)
                ren_q <= 1'b1;
            else if (rx_stop)
                ren_q <= 1'b0;
            else if (wr & rd_hit & paddr[9:2] == IDX_RECEIVE_STATUS)
                ren_q <= 1'b0;
            done_q <= (done_q & ~ren_set) | fin_done;
            crc_error_q <= (crc_error_q & ~ren_set) | fin_crc_error;
            ae_q   <= (ae_q & ~ren_set) | fin_ae;
            abt_q  <= (abt_q & ~ren_set) | abt_ev;
            ovr_q  <= (ovr_q & ~(wr & rd_hit & paddr[9:2] == IDX_RECEIVE_STATUS
                                 & ~pwdata[ST_OVR])) | ovr_ev;
        end
    end

    // Line driver: jam, data (NRZI when sdlc, plain in CSMA/CD) or idle flags, on the internal clock
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tx_line <= 1'b1;
            jam_q   <= 6'h00;
            jsh_q   <= 32'h00000000;
            flag_q  <= IDLE_FLAG;
        end
        else if (coll_ev & tx_busy & ~sdlc & jam_q == 6'h00)
        begin
            jam_q <= crc32 ? JAM32_BITS : JAM16_BITS;
            jsh_q <= ~crc_q;
        end
        else if (tx_tick)
        begin
            if (jam_q != 6'h00)
            begin
                tx_line <= slot_q[SL_JAM] ? 1'b0 : jsh_q[0];
                jsh_q   <= {1'b0, jsh_q[31:1]};
                jam_q   <= jam_q - 6'h01;
            end
            else if (sdlc)
            begin
                if (~tx_busy & pctl_q[PC_FLAG_IDLE])
                begin
                    flag_q  <= {flag_q[0], flag_q[7:1]};
                    tx_line <= flag_q[0] ? tx_line : ~tx_line;
                end
                else if (tx_busy & ~tx_bit)
                    tx_line <= ~tx_line;
            end
            else
                tx_line <= tx_busy ? tx_bit : 1'b1;
        end
    end

    // Backoff slot choice and other block outputs
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            backoff_slot <= 6'h00;
            backoff_join <= 1'b0;
            collision    <= 1'b0;
            hw_ack_en    <= 1'b0;
        end
        else
        begin
            backoff_slot <= slot_q[SL_DET] ? slot_q[5:0] : backoff_random_source_q[5:0];
            backoff_join <= ~(slot_q[SL_DET] & slot_q[5:0] == 6'h00);
            collision    <= coll_ev;
            hw_ack_en    <= hwack_q;
        end
    end
endmodule

/* sfrs_props.sv */
// Checker for bus timing, status outputs and backoff of the block
`timescale 1ns/1ps
module sfrs_props
    import sfrs_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        collision,
    input wire logic [5:0]  backoff_slot,
    input wire logic        backoff_join,
    input wire logic        hw_ack_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic wr_q;
    logic wr_receive_status;
    logic wr_slot;
    // Completed writes; outputs lag the register by one more cycle
    assign wr_q = psel && penable && pready && pwrite;
    assign wr_receive_status = wr_q && paddr == {2'h0, IDX_RECEIVE_STATUS, 2'h0};
    assign wr_slot = wr_q && paddr == {2'h0, IDX_SLOT, 2'h0};

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("access phase not two cycles");
    a_err_unaligned: assert property (
        psel && $rose(penable) && paddr[1:0] != 2'h0 |-> ##1 pready && pslverr)
        else $error("misaligned access not refused");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_err_no_data: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    a_hwack_copy: assert property (
        wr_receive_status |=> ##1 hw_ack_en == $past(pwdata[ST_HWACK], 2))
        else $error("hw ack enable not following status bit");
    a_det_slot: assert property (
        wr_slot && pwdata[SL_DET] |=> ##1 backoff_slot == $past(pwdata[5:0], 2))
        else $error("deterministic slot not used");
    a_zero_slot_out: assert property (
        wr_slot && pwdata[SL_DET] && pwdata[5:0] == 6'h0 |=> ##1 !backoff_join)
        else $error("slot zero still joins backoff");
    a_collision_pulse: assert property (collision |=> !collision)
        else $error("collision pulse too long");
endmodule

bind sfrs_top sfrs_props sfrs_props_i (.mclk, .rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .collision, .backoff_slot,
    .backoff_join, .hw_ack_en);

/* sfrs_remote.sv */
// Remote station: drives the receive line and its external bit clock
`timescale 1ns/1ps
module sfrs_remote
    import sfrs_pkg::*;
(
    output logic rx_data_pin,
    output logic rx_clk_pin
);
    logic [15:0] crc_q;
    logic [7:0]  acc;
    logic [7:0]  sent[$];
    int          nb;
    int          ones;
    initial
    begin
        rx_data_pin = 1'b1;
        rx_clk_pin = 1'b0;
    end
    // One tick; the clock stands still low between frames
    task automatic tick(input logic lv);
        #40 rx_data_pin = lv;
        #40 rx_clk_pin = 1'b1;
        #80 rx_clk_pin = 1'b0;
    endtask
    // A zero flips the level, a one holds it
    task automatic nrzi(input logic b);
        tick(b ? rx_data_pin : ~rx_data_pin);
    endtask
    // Payload bit: CRC, byte assembly, zero inserted after five ones
    task automatic dbit(input logic b);
        nrzi(b);
        crc_q = {crc_q[14:0], 1'b0}
            ^ (crc_q[15] ^ b ? CRC16_POLY[15:0] : 16'h0);
        acc = {b, acc[7:1]};
        nb++;
        if (nb % 8 == 0)
            sent.push_back(acc);
        ones = b ? ones + 1 : 0;
        if (ones == 5)
        begin
            nrzi(1'b0);
            ones = 0;
        end
    endtask
    task automatic flag();
        for (int k = 0; k < 8; k++)
            nrzi(IDLE_FLAG[k]);
    endtask
    // Two flags, payload LSB first, inverted check MSB first, flag
    task automatic send_frame(input logic [7:0] d[$], input logic bad);
        logic [15:0] fcs;
        sent.delete();
        crc_q = CRC_INIT[15:0];
        nb = 0;
        ones = 0;
        repeat (2) flag();
        foreach (d[i])
            for (int k = 0; k < 8; k++)
                dbit(d[i][k]);
        fcs = ~crc_q ^ {15'h0, bad};
        for (int k = 15; k >= 0; k--)
            dbit(fcs[k]);
        flag();
    endtask
endmodule

/* sfrs_top_tb.sv */
// Self-checking bench: registers, frame reception, backoff, collision
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module sfrs_top_tb;
    import sfrs_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] paddr = 12'h0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic        tx_bit = 1'b0;
    logic        tx_busy = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, rx_data_pin, rx_clk_pin, tx_line;
    logic        collision, backoff_join, hw_ack_en, rerr;
    logic [5:0]  backoff_slot;
    logic [7:0]  rdat, v;
    logic [7:0]  regs[4] = '{IDX_CHAN_MODE, IDX_PWR_CTRL, IDX_RECEIVE_STATUS, IDX_SLOT};
    int          num_errors = 0, n_tests = 0, cyc = 0, ncol = 0;

    sfrs_top sfrs_top_i (.mclk, .rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .rx_data_pin, .rx_clk_pin,
        .tx_busy, .tx_bit, .tx_line, .collision, .backoff_slot,
        .backoff_join, .hw_ack_en);
    sfrs_remote sfrs_remote_i (.rx_data_pin, .rx_clk_pin);

    always #10 mclk = ~mclk;
    // Timeout, collision count and random transmit data
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        tx_bit <= 1'($urandom);
        if (collision === 1'b1)
            ncol++;
        if (cyc == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    // One transfer; waits for ready, releases one edge later
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
        // A slave that never answers counts as a mismatch
        if (n >= 50)
            num_errors++;
        rdat = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // Send a frame, poll until the receiver stops, check status
    task automatic frame(input int nd, input logic bad, input logic [7:0] msk,
                         input logic [7:0] ex);
        logic [7:0] d[$];
        int n;
        n = 0;
        repeat (nd) d.push_back(8'($urandom));
        sfrs_remote_i.send_frame(d, bad);
        do apb(1'b0, ad(IDX_RECEIVE_STATUS), 8'h0);
        while (rdat[ST_REN] === 1'b1 && ++n < 30);
        `CHK(rdat & msk, ex)
    endtask
    // Pop oldest first, then empty reads give zero
    task automatic drain(input int nb);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b0, ad(IDX_RECEIVE_FIFO_PORT), 8'h0);
            `CHK(rdat, k < nb ? sfrs_remote_i.sent[k] : 8'h0)
        end
        apb(1'b0, ad(IDX_RECEIVE_STATUS), 8'h0);
        `CHK(rdat[ST_NE], 1'b0)
    endtask

    initial
    begin
        void'($urandom(49));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // Reset values, read-only source, refused addresses
        foreach (regs[i])
        begin
            apb(1'b0, ad(regs[i]), 8'h0);
            `CHK(rdat, REG_RST)
        end
        apb(1'b0, ad(IDX_BACKOFF_RANDOM_SOURCE), 8'h0);
        v = rdat;
        apb(1'b1, ad(IDX_BACKOFF_RANDOM_SOURCE), 8'h0);
        apb(1'b0, ad(IDX_BACKOFF_RANDOM_SOURCE), 8'h0);
        `CHK(rdat != v && rdat != 8'h0 && v != 8'h0, 1'b1)
        apb(1'b0, ad(8'h10), 8'h0);
        `CHK({rerr, rdat}, 9'h100)
        apb(1'b0, ad(IDX_SLOT) + 12'h1, 8'h0);
        `CHK(rerr, 1'b1)
        // Slot settings drive the backoff outputs
        for (int i = 0; i < 6; i++)
        begin
            v = 8'($urandom);
            if (i == 0)
                v[6:0] = 7'h40;
            if (i == 1)
                v[6] = 1'b0;
            apb(1'b1, ad(IDX_SLOT), v);
            apb(1'b0, ad(IDX_SLOT), 8'h0);
            `CHK(rdat, v)
            `CHK(backoff_join, !(v[6] && v[5:0] == 6'h0))
            if (v[6])
                `CHK(backoff_slot, v[5:0])
        end
        apb(1'b1, ad(IDX_RECEIVE_STATUS), 8'h01);
        apb(1'b0, ad(IDX_RECEIVE_STATUS), 8'h0);
        `CHK({hw_ack_en, rdat}, 9'h101)
        apb(1'b1, ad(IDX_PWR_CTRL), 8'h08);
        apb(1'b0, ad(IDX_PWR_CTRL), 8'h0);
        `CHK(rdat, 8'h08)
        // Low-low on the line with the receiver off still collides
        // Transmitter busy with a steady-low jam selected
        apb(1'b1, ad(IDX_RECEIVE_STATUS), 8'h00);
        apb(1'b1, ad(IDX_SLOT), 8'h80);
        tx_busy <= 1'b1;
        repeat (6) sfrs_remote_i.tick(1'b0);
        repeat (2) sfrs_remote_i.tick(1'b1);
        repeat (8) @(posedge mclk);
        `CHK(ncol > 0, 1'b1)
        `CHK(tx_line, 1'b0)
        tx_busy <= 1'b0;
        // Jam of sixteen bit ticks over, line idles high
        repeat (160) @(posedge mclk);
        `CHK(tx_line, 1'b1)
        apb(1'b1, ad(IDX_CHAN_MODE), 8'h01);
        apb(1'b0, ad(IDX_CHAN_MODE), 8'h0);
        `CHK(rdat, 8'h01)
        // Good, bad-check, flush, overrun and disabled frames
        apb(1'b1, ad(IDX_RECEIVE_STATUS), 8'h02);
        frame(1, 1'b0, 8'hfe, 8'h0c);
        drain(3);
        apb(1'b1, ad(IDX_RECEIVE_STATUS), 8'h02);
        frame(1, 1'b1, 8'hfe, 8'h14);
        apb(1'b1, ad(IDX_RECEIVE_STATUS), 8'h02);
        apb(1'b0, ad(IDX_RECEIVE_STATUS), 8'h0);
        `CHK(rdat, 8'h02)
        frame(2, 1'b0, 8'h8e, 8'h84);
        drain(3);
        apb(1'b1, ad(IDX_RECEIVE_STATUS), 8'h00);
        frame(1, 1'b0, 8'h8e, 8'h00);
        drain(0);
        report_and_stop();
    end
endmodule
